// ---- rtl/afsm_pkg.sv ----
// fault status and report mask register bank: shared constants and types
// assumes an 8-bit register port with byte addresses as printed
`default_nettype none
package afsm_pkg;
   // ***********************************************************
   // register map
   // ***********************************************************
   localparam logic [7:0] ADDR_CHANNEL_FAULT_STATUS = 8'h70;
   localparam logic [7:0] ADDR_GLOBAL_A = 8'h71;
   localparam logic [7:0] ADDR_GLOBAL_B = 8'h72;
   localparam logic [7:0] ADDR_WARNING = 8'h73;
   localparam logic [7:0] ADDR_MASK_A = 8'h74;
   localparam logic [7:0] ADDR_MASK_B = 8'h75;
   localparam logic [7:0] ADDR_FAULT_CLEAR = 8'h78;

   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic [7:0] RST_MASK_A = 8'h00;
   localparam logic [7:0] RST_MASK_B = 8'hf8;
   // bit 3 of mask a is reserved and read-only
   localparam logic [7:0] WMASK_MASK_A = 8'hf7;
   localparam int CLEAR_BIT = 7;

   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int MA_THERMAL_SD = 7;
   localparam int MA_CORE_UV = 6;
   localparam int MA_CORE_OV = 5;
   localparam int MA_CLOCK = 4;
   localparam int MA_STAGE = 2;
   localparam int MA_DC = 1;
   localparam int MA_OC = 0;
   localparam int MB_HOLD_CBC_FAULT = 7;
   localparam int MB_HOLD_CBC_WARN = 6;
   localparam int MB_HOLD_CLOCK = 5;
   localparam int MB_HOLD_THERMAL_SD = 4;
   localparam int MB_HOLD_THERMAL_WARN = 3;
   localparam int MB_THERMAL_WARN = 2;
   localparam int MB_CBC_WARN = 1;
   localparam int MB_CBC_FAULT = 0;

   // sticky vector layout
   localparam int STICKY_W = 16;
   localparam int SV_R_OC = 0;
   localparam int SV_L_OC = 1;
   localparam int SV_R_DC = 2;
   localparam int SV_L_DC = 3;
   localparam int SV_STAGE_UV = 4;
   localparam int SV_STAGE_OV = 5;
   localparam int SV_CLOCK = 6;
   localparam int SV_THERMAL_SD = 7;
   localparam int SV_L_CBC = 8;
   localparam int SV_R_CBC = 9;
   localparam int SV_L_CBCW = 10;
   localparam int SV_R_CBCW = 11;
   localparam int SV_OTW = 12;

   // warning thresholds in degrees C, informational for level inputs
   localparam int OTW_LEVEL_ONE_C = 112;
   localparam int OTW_LEVEL_TWO_C = 122;
   localparam int OTW_LEVEL_THREE_C = 134;
   localparam int OTW_LEVEL_FOUR_C = 146;

   // ***********************************************************
   // state types
   // ***********************************************************
   typedef struct packed {
      logic [STICKY_W-1:0] held;
   } afsm_sticky_s;

   typedef struct packed {
      logic [7:0] maskA;
      logic [7:0] maskB;
      logic [2:0] digital;
      logic [7:0] rdData;
      logic rdValid;
      logic [7:0] rdAddr;
      logic clearPulse;
      logic reportN;
   } afsm_regs_s;
endpackage
`default_nettype wire

// ---- rtl/afsm_sticky.sv ----
// latched fault flags with per-bit hold enables
// assumes raw flags are synchronous to mclk
`timescale 1ns/100ps
`default_nettype none
module afsm_sticky
   import afsm_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [STICKY_W-1:0] rawIn,
   input wire logic [STICKY_W-1:0] holdEn,
   input wire logic clearHeld,
   output logic [STICKY_W-1:0] heldState
);
   afsm_sticky_s state_r;
   afsm_sticky_s state_nxt;

   // ***********************************************************
   // latch logic
   // ***********************************************************
   always_comb
   begin
      state_nxt = state_r;
      // set beats clear so a fault landing on the clear is kept
      state_nxt.held = rawIn
         | (holdEn & state_r.held & {STICKY_W{~clearHeld}});
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         state_r <= '0;
      else if (ce)
         state_r <= state_nxt;
   end

   assign heldState = state_r.held;

   // ***********************************************************
   // checks
   // ***********************************************************
   a_set_visible: assert property (@(posedge mclk) disable iff (rst)
      ce |=> ((heldState & $past(rawIn)) == $past(rawIn)))
      else $error("active raw fault not shown in status");

   a_hold_keeps: assert property (@(posedge mclk) disable iff (rst)
      (ce && !clearHeld) |=>
         ((heldState & $past(state_r.held & holdEn))
            == $past(state_r.held & holdEn)))
      else $error("held fault dropped without clear");

   a_clear_drops: assert property (@(posedge mclk) disable iff (rst)
      (ce && clearHeld) |=> (heldState == $past(rawIn)))
      else $error("clear did not reduce status to live faults");
endmodule
`default_nettype wire

// ---- rtl/afsm_regs.sv ----
// fault and warning status, report masks and fault clear of the amplifier
// assumes fault inputs are synchronous levels from the protection circuits
// and a simple byte register port decoded by the control interface
`timescale 1ns/100ps
`default_nettype none
module afsm_regs
   import afsm_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic left_dc_fault,
   input wire logic right_dc_fault,
   input wire logic left_overcurrent_fault,
   input wire logic right_overcurrent_fault,
   input wire logic configCrcError,
   input wire logic coefficient_write_error,
   input wire logic bootLoadError,
   input wire logic clockFault,
   input wire logic stageOverVolt,
   input wire logic stageUnderVolt,
   input wire logic coreUnderVolt,
   input wire logic coreOverVolt,
   input wire logic left_cycle_limit_fault,
   input wire logic right_cycle_limit_fault,
   input wire logic thermal_shutdown_fault,
   input wire logic left_cycle_limit_warning,
   input wire logic right_cycle_limit_warning,
   input wire logic [3:0] thermalWarning,
   output logic [7:0] regRdData,
   output logic regRdValid,
   output logic analogClear,
   output logic faultReportN
);
   afsm_regs_s state_r;
   afsm_regs_s state_nxt;
   logic [STICKY_W-1:0] rawFaults;
   logic [STICKY_W-1:0] holdMask;
   logic [STICKY_W-1:0] held;

   // ***********************************************************
   // helpers
   // ***********************************************************
   // any unmasked source, shared by report logic and its check
   function automatic logic anyUnmasked(input logic [STICKY_W-1:0] st,
                                        input logic [7:0] ma,
                                        input logic [7:0] mb,
                                        input logic cuv,
                                        input logic cov);
      logic hit;
      hit = 1'b0;
      hit = hit | (st[SV_THERMAL_SD] & ~ma[MA_THERMAL_SD]);
      hit = hit | (cuv & ~ma[MA_CORE_UV]);
      hit = hit | (cov & ~ma[MA_CORE_OV]);
      hit = hit | (st[SV_CLOCK] & ~ma[MA_CLOCK]);
      hit = hit | ((st[SV_STAGE_UV] | st[SV_STAGE_OV])
         & ~ma[MA_STAGE]);
      hit = hit | ((st[SV_L_DC] | st[SV_R_DC]) & ~ma[MA_DC]);
      hit = hit | ((st[SV_L_OC] | st[SV_R_OC]) & ~ma[MA_OC]);
      hit = hit | ((|st[SV_OTW+3:SV_OTW]) & ~mb[MB_THERMAL_WARN]);
      hit = hit | ((st[SV_L_CBCW] | st[SV_R_CBCW])
         & ~mb[MB_CBC_WARN]);
      hit = hit | ((st[SV_L_CBC] | st[SV_R_CBC]) & ~mb[MB_CBC_FAULT]);
      return hit;
   endfunction

   // ***********************************************************
   // fault gathering
   // ***********************************************************
   assign rawFaults = {thermalWarning, right_cycle_limit_warning,
      left_cycle_limit_warning, right_cycle_limit_fault,
      left_cycle_limit_fault, thermal_shutdown_fault, clockFault,
      stageOverVolt, stageUnderVolt, left_dc_fault, right_dc_fault,
      left_overcurrent_fault, right_overcurrent_fault};

   // stage supply, DC and over-current faults always hold until cleared
   assign holdMask = {{4{state_r.maskB[MB_HOLD_THERMAL_WARN]}},
      {2{state_r.maskB[MB_HOLD_CBC_WARN]}},
      {2{state_r.maskB[MB_HOLD_CBC_FAULT]}},
      state_r.maskB[MB_HOLD_THERMAL_SD],
      state_r.maskB[MB_HOLD_CLOCK], 6'h3f};

   afsm_sticky u_sticky (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .rawIn(rawFaults),
      .holdEn(holdMask),
      .clearHeld(state_r.clearPulse),
      .heldState(held)
   );

   // ***********************************************************
   // register access
   // ***********************************************************
   always_comb
   begin
      state_nxt = state_r;
      state_nxt.rdValid = 1'b0;
      state_nxt.clearPulse = 1'b0;
      state_nxt.digital = {configCrcError, coefficient_write_error,
         bootLoadError};
      // writes to status addresses fall through untouched
      if (regWrEn)
      begin
         case (regAddr)
            ADDR_MASK_A:
               state_nxt.maskA = regWrData & WMASK_MASK_A;
            ADDR_MASK_B:
               state_nxt.maskB = regWrData;
            ADDR_FAULT_CLEAR:
               state_nxt.clearPulse = regWrData[CLEAR_BIT];
            default:
               state_nxt.clearPulse = 1'b0;
         endcase
      end
      if (regRdEn)
      begin
         state_nxt.rdValid = 1'b1;
         state_nxt.rdAddr = regAddr;
         case (regAddr)
            ADDR_CHANNEL_FAULT_STATUS:
               state_nxt.rdData = {4'h0, held[SV_L_DC], held[SV_R_DC],
                  held[SV_L_OC], held[SV_R_OC]};
            ADDR_GLOBAL_A:
               state_nxt.rdData = {state_r.digital, 2'h0, held[SV_CLOCK],
                  held[SV_STAGE_OV], held[SV_STAGE_UV]};
            ADDR_GLOBAL_B:
               state_nxt.rdData = {5'h00, held[SV_R_CBC], held[SV_L_CBC],
                  held[SV_THERMAL_SD]};
            ADDR_WARNING:
               state_nxt.rdData = {2'h0, held[SV_L_CBCW], held[SV_R_CBCW],
                  held[SV_OTW+3:SV_OTW]};
            ADDR_MASK_A:
               state_nxt.rdData = state_r.maskA;
            ADDR_MASK_B:
               state_nxt.rdData = state_r.maskB;
            default:
               state_nxt.rdData = 8'h00;
         endcase
      end
      // status keeps updating under a mask; only the report is gated
      state_nxt.reportN = ~anyUnmasked(held, state_r.maskA, state_r.maskB,
         coreUnderVolt, coreOverVolt);
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= '0;
         state_r.maskA <= RST_MASK_A;
         state_r.maskB <= RST_MASK_B;
         state_r.rdData <= RST_STATUS;
         state_r.reportN <= 1'b1;
      end
      else if (ce)
         state_r <= state_nxt;
   end

   assign regRdData = state_r.rdData;
   assign regRdValid = state_r.rdValid;
   assign analogClear = state_r.clearPulse;
   assign faultReportN = state_r.reportN;

   // ***********************************************************
   // checks
   // ***********************************************************
   sequence s_clear_write;
      ce && regWrEn && (regAddr == ADDR_FAULT_CLEAR) && regWrData[CLEAR_BIT];
   endsequence

   sequence s_read_of(logic [7:0] a);
      ce && regRdEn && (regAddr == a);
   endsequence

   a_mask_write: assert property (@(posedge mclk) disable iff (rst)
      (ce && regWrEn && regAddr == ADDR_MASK_A) |=>
         (state_r.maskA == ($past(regWrData) & WMASK_MASK_A)))
      else $error("mask a write not stored with reserved bit zero");

   a_clear_pulse: assert property (@(posedge mclk) disable iff (rst)
      s_clear_write |=> analogClear)
      else $error("clear write gave no clear pulse");

   a_chan_read: assert property (@(posedge mclk) disable iff (rst)
      s_read_of(ADDR_CHANNEL_FAULT_STATUS) |=> regRdValid && regRdData[7:4] == 4'h0
         && regRdData[3:0] == $past({held[SV_L_DC], held[SV_R_DC],
            held[SV_L_OC], held[SV_R_OC]}))
      else $error("channel status read wrong");

   a_boot_read: assert property (@(posedge mclk) disable iff (rst)
      s_read_of(ADDR_GLOBAL_A) |=>
         regRdData[5] == $past(state_r.digital[0]) && regRdData[4:3] == 2'h0)
      else $error("boot load flag read wrong");

   a_warn_read: assert property (@(posedge mclk) disable iff (rst)
      s_read_of(ADDR_WARNING) |=> regRdData[7:6] == 2'h0
         && regRdData[5:4] == $past({held[SV_L_CBCW], held[SV_R_CBCW]}))
      else $error("warning read wrong");

   a_shutdown_read: assert property (@(posedge mclk) disable iff (rst)
      s_read_of(ADDR_GLOBAL_B) |=>
         regRdData == $past({5'h00, held[SV_R_CBC], held[SV_L_CBC],
            held[SV_THERMAL_SD]}))
      else $error("global b read wrong");

   a_report_low: assert property (@(posedge mclk) disable iff (rst)
      (ce && anyUnmasked(held, state_r.maskA, state_r.maskB,
         coreUnderVolt, coreOverVolt)) |=> !faultReportN)
      else $error("unmasked fault not reported");

   a_report_high: assert property (@(posedge mclk) disable iff (rst)
      (ce && !anyUnmasked(held, state_r.maskA, state_r.maskB,
         coreUnderVolt, coreOverVolt)) |=> faultReportN)
      else $error("report active with all sources masked or clear");

   a_ro_ignored: assert property (@(posedge mclk) disable iff (rst)
      (ce && regWrEn && regAddr != ADDR_MASK_A && regAddr != ADDR_MASK_B)
         |=> $stable(state_r.maskA) && $stable(state_r.maskB))
      else $error("write to other address changed a mask");

   // clear write taken, then the pulse reaches the sticky flags
   sequence s_clear_taken;
      s_clear_write ##1 (ce && analogClear);
   endsequence

   a_clear_effect: assert property (@(posedge mclk) disable iff (rst)
      s_clear_taken |=> (held == $past(rawFaults)))
      else $error("clear left a fault that is no longer live");

   a_clear_single: assert property (@(posedge mclk) disable iff (rst)
      (ce && !(regWrEn && regAddr == ADDR_FAULT_CLEAR
         && regWrData[CLEAR_BIT])) |=> !analogClear)
      else $error("clear pulse without a clear write");

   a_valid_pulse: assert property (@(posedge mclk) disable iff (rst)
      (ce && !regRdEn) |=> !regRdValid)
      else $error("read valid without a read strobe");

   a_data_holds: assert property (@(posedge mclk) disable iff (rst)
      (ce && !regRdEn) |=> $stable(regRdData))
      else $error("read data changed without a read");

   a_mask_b_write: assert property (@(posedge mclk) disable iff (rst)
      (ce && regWrEn && regAddr == ADDR_MASK_B) |=>
         (state_r.maskB == $past(regWrData)))
      else $error("mask b write not stored");

   a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
      (state_r.maskA & ~WMASK_MASK_A) == 8'h00)
      else $error("reserved mask bit set");

   a_global_read: assert property (@(posedge mclk) disable iff (rst)
      s_read_of(ADDR_GLOBAL_A) |=>
         regRdData[7:6] == $past(state_r.digital[2:1])
         && regRdData[2:0] == $past({held[SV_CLOCK], held[SV_STAGE_OV],
            held[SV_STAGE_UV]}))
      else $error("global a read wrong");

   a_level_read: assert property (@(posedge mclk) disable iff (rst)
      s_read_of(ADDR_WARNING) |=>
         regRdData[3:0] == $past(held[SV_OTW+3:SV_OTW]))
      else $error("thermal warning levels read wrong");

   a_unmapped_read: assert property (@(posedge mclk) disable iff (rst)
      (ce && regRdEn && (regAddr < ADDR_CHANNEL_FAULT_STATUS || regAddr > ADDR_MASK_B))
         |=> regRdData == 8'h00)
      else $error("unmapped read not zero");

   a_mask_read: assert property (@(posedge mclk) disable iff (rst)
      s_read_of(ADDR_MASK_A) |=> regRdData == $past(state_r.maskA))
      else $error("mask a read wrong");

   a_maskb_read: assert property (@(posedge mclk) disable iff (rst)
      s_read_of(ADDR_MASK_B) |=> regRdData == $past(state_r.maskB))
      else $error("mask b read wrong");

   // source by source, independent of the shared report function
   a_hot_report: assert property (@(posedge mclk) disable iff (rst)
      (ce && held[SV_THERMAL_SD] && !state_r.maskA[MA_THERMAL_SD])
         |=> !faultReportN)
      else $error("unmasked thermal shutdown not reported");

   a_dc_report: assert property (@(posedge mclk) disable iff (rst)
      (ce && (held[SV_L_DC] || held[SV_R_DC]) && !state_r.maskA[MA_DC])
         |=> !faultReportN)
      else $error("unmasked dc fault not reported");

   a_core_report: assert property (@(posedge mclk) disable iff (rst)
      (ce && coreUnderVolt && !state_r.maskA[MA_CORE_UV])
         |=> !faultReportN)
      else $error("unmasked core undervoltage not reported");
endmodule
`default_nettype wire

// ---- verif/afsm_regs_tb.sv ----
// testbench for the fault status and report mask register bank
// assumes the byte register port and fault level inputs of afsm_regs
`timescale 1ns/100ps
`default_nettype none
module afsm_regs_tb;
   // ***********************************************************
   // stimulus and design
   // ***********************************************************
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   // one bit per fault input, four for thermalWarning, see port map below
   logic [20:0] flt = 21'h0;
   logic [7:0] regRdData;
   logic regRdValid;
   logic analogClear;
   logic faultReportN;
   int mismatches = 0;
   int n_tests = 0;

   always #2 mclk = ~mclk;

   afsm_regs uut (.mclk(mclk), .rst(rst), .ce(ce), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .left_dc_fault(flt[0]), .right_dc_fault(flt[1]),
      .left_overcurrent_fault(flt[2]), .right_overcurrent_fault(flt[3]),
      .configCrcError(flt[4]), .coefficient_write_error(flt[5]),
      .bootLoadError(flt[6]), .clockFault(flt[7]),
      .stageOverVolt(flt[8]), .stageUnderVolt(flt[9]),
      .coreUnderVolt(flt[10]), .coreOverVolt(flt[11]),
      .left_cycle_limit_fault(flt[12]), .right_cycle_limit_fault(flt[13]),
      .thermal_shutdown_fault(flt[14]),
      .left_cycle_limit_warning(flt[15]),
      .right_cycle_limit_warning(flt[16]),
      .thermalWarning(flt[20:17]), .regRdData(regRdData),
      .regRdValid(regRdValid), .analogClear(analogClear),
      .faultReportN(faultReportN));

   // ***********************************************************
   // access tasks and expectations
   // ***********************************************************
   task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
   begin
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d,
      output logic clr);
   begin
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge mclk);
      regWrEn <= 1'b0;
      #1 clr = analogClear;
   end
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
   begin
      @(posedge mclk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge mclk);
      regRdEn <= 1'b0;
      #1;
      chk("rdValid", {7'h0, regRdValid}, 8'h01);
      d = regRdData;
   end
   endtask

   // raw flags need one edge to be held and one more to reach report
   task automatic set_flt(input logic [20:0] v);
   begin
      @(posedge mclk);
      flt <= v;
      repeat (3) @(posedge mclk);
      #1;
   end
   endtask

   task automatic chk_status(input logic [20:0] v);
      logic [7:0] d;
      logic [7:0] e [4];
   begin
      e[0] = {4'h0, v[0], v[1], v[2], v[3]};
      e[1] = {v[4], v[5], v[6], 2'b00, v[7], v[8], v[9]};
      e[2] = {5'h00, v[13], v[12], v[14]};
      e[3] = {2'b00, v[15], v[16], v[20:17]};
      for (int k = 0; k < 4; k++)
      begin
         rd(8'h70 + 8'(k), d);
         chk("status", d, e[k]);
      end
   end
   endtask

   function automatic logic rep(input int i, input logic [7:0] ma,
      input logic [7:0] mb);
   begin
      case (i)
         0, 1: rep = !ma[1];
         2, 3: rep = !ma[0];
         7: rep = !ma[4];
         8, 9: rep = !ma[2];
         10: rep = !ma[6];
         11: rep = !ma[5];
         12, 13: rep = !mb[0];
         14: rep = !ma[7];
         15, 16: rep = !mb[1];
         17, 18, 19, 20: rep = !mb[2];
         default: rep = 1'b0;
      endcase
   end
   endfunction

   function automatic logic lat(input int i, input logic [7:0] mb);
   begin
      case (i)
         0, 1, 2, 3, 8, 9: lat = 1'b1;
         7: lat = mb[5];
         12, 13: lat = mb[7];
         14: lat = mb[4];
         15, 16: lat = mb[6];
         17, 18, 19, 20: lat = mb[3];
         default: lat = 1'b0;
      endcase
   end
   endfunction

   // ***********************************************************
   // tests
   // ***********************************************************
   task automatic reset_check(input string name);
      logic [7:0] d;
      logic [7:0] adr [8] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75,
         8'h78, 8'h7f};
      logic [7:0] exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hf8,
         8'h00, 8'h00};
   begin
      for (int k = 0; k < 8; k++)
      begin
         rd(adr[k], d);
         chk("reset value", d, exp[k]);
      end
      chk("reset report", {7'h0, faultReportN}, 8'h01);
      $display("test %s done", name);
   end
   endtask

   task automatic run_pass(input string name, input logic [7:0] ma,
      input logic [7:0] mb);
      logic [7:0] d;
      logic c;
      logic [20:0] v;
   begin
      wr(8'h74, ma, c);
      wr(8'h75, mb, c);
      rd(8'h74, d);
      chk("maskA", d, ma & 8'hf7);
      rd(8'h75, d);
      chk("maskB", d, mb);
      for (int i = 0; i < 21; i++)
      begin
         v = 21'h1 << i;
         set_flt(v);
         chk("report", {7'h0, faultReportN},
            {7'h0, !rep(i, ma, mb)});
         chk_status(v);
         set_flt(21'h0);
         if (i != 10 && i != 11)
            chk("held report", {7'h0, faultReportN},
               {7'h0, !(lat(i, mb) && rep(i, ma, mb))});
         chk_status(lat(i, mb) ? v : 21'h0);
         wr(8'h78, 8'h80, c);
         chk("clear pulse", {7'h0, c}, 8'h01);
         repeat (3) @(posedge mclk);
         #1;
         chk_status(21'h0);
         chk("cleared report", {7'h0, faultReportN}, 8'h01);
      end
      $display("test %s done", name);
   end
   endtask

   task automatic refuse_test;
      logic [7:0] d;
      logic c;
   begin
      set_flt(21'h1);
      // clear while the fault is still live: the set must win
      wr(8'h78, 8'h80, c);
      repeat (2) @(posedge mclk);
      chk_status(21'h1);
      set_flt(21'h0);
      wr(8'h70, 8'h00, c);
      wr(8'h73, 8'hff, c);
      wr(8'h78, 8'h7f, c);
      chk("no clear", {7'h0, c}, 8'h00);
      chk_status(21'h1);
      rd(8'h7f, d);
      chk("unmapped", d, 8'h00);
      wr(8'h78, 8'h80, c);
      repeat (3) @(posedge mclk);
      chk_status(21'h0);
      rd(8'h74, d);
      chk("maskA kept", d, 8'h00);
      rd(8'h75, d);
      chk("maskB kept", d, 8'hf8);
      // a fault that comes and goes while ce is low is never seen
      @(posedge mclk);
      ce <= 1'b0;
      flt <= 21'h1;
      repeat (3) @(posedge mclk);
      flt <= 21'h0;
      @(posedge mclk);
      ce <= 1'b1;
      chk_status(21'h0);
      $display("test refuse done");
   end
   endtask

   task automatic final_report;
   begin
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask

   // one pass costs about 785 cycles, the watchdog at 50000 cycles allows over sixty times that
   initial
   begin
      #200000;
      mismatches++;
      $display("watchdog expired");
      final_report();
   end

   initial
   begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      reset_check("reset");
      run_pass("default_masks", 8'h00, 8'hf8);
      refuse_test();
      run_pass("masks_even", 8'h5d, 8'hfa);
      run_pass("masks_odd", 8'ha2, 8'h05);
      // reset in mid-run with a latched fault must drop it and the masks
      set_flt(21'h8);
      @(posedge mclk);
      rst <= 1'b1;
      flt <= 21'h0;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      reset_check("second_reset");
      final_report();
   end
endmodule
`default_nettype wire
